// *** rtl/pde_defines.svh ***
// constants for the paged data eeprom controller
// Functional notes
// R1: 64-byte pages mapped at data 00h-3Fh
// R2: no page or standby gives meaningless access
// R3: standby bit 6 disables array, low power
// R4: writes need program enable bit 0
// R5: busy flag bit 1 during programming
// R6: accesses aborted while busy; programming completes
// R7: control writes ignored while busy
// R8: idle read behaves like RAM read
// R9: byte mode programs target directly
// R10: eight rows of eight bytes per page
// R11: entering row mode clears row latches
// R12: row mode latches row; other rows error
// R13: row start programs only loaded bytes
// R14: row cycle end clears mode and start
// R15: start needs enable and row mode set
// R16: leaving row mode abandons latches
// R17: software avoids reads in row mode
// R18: software writes zero to bits 4,5
// R19: no read-modify-write on control register
// R20: isr writers keep a shadow copy first
// R21: erased bytes read FFh
// R22: bank 01h page0, 02h page1, 00h none
// R23: programming time is a cycle parameter
`ifndef PDE_DEFINES_SVH
`define PDE_DEFINES_SVH
`define PDE_CTL_ADDR   8'hdf
`define PDE_BANK_ADDR  8'hcb
`define PDE_WIN_TOP    8'h3f
`define PDE_BIT_ENA    0
`define PDE_BIT_BUSY   1
`define PDE_BIT_ROWEN  2
`define PDE_BIT_START  3
`define PDE_BIT_STBY   6
`define PDE_RSVD_MASK  8'h30
`define PDE_CTL_RESET  8'h00
`define PDE_ERASED     8'hff
`define PDE_BANK_P0    8'h01
`define PDE_BANK_P1    8'h02
`define PDE_PROG_CYC   16'h0100
`endif

// *** rtl/pde_pkg.sv ***
// types shared by both ends
package pde_pkg;
	typedef logic [7:0] pde_byte_t;
	typedef enum logic [1:0] {
		PDE_IDLE = 2'b00,
		PDE_PROG = 2'b01,
		PDE_DONE = 2'b11
	} pde_state_e;
endpackage

// *** rtl/pde_if.sv ***
// core data bus between cpu side and eeprom controller
`timescale 1ns/1ps
`default_nettype none
interface pde_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       err;
	modport dev (input addr, wdata, wr, rd, output rdata, err);
	modport host (output addr, wdata, wr, rd, input rdata, err);
endinterface
`default_nettype wire

// *** rtl/pde_prog_timer.sv ***
// programming cycle timer
`timescale 1ns/1ps
`default_nettype none
`include "pde_defines.svh"
module pde_prog_timer #(
	parameter logic [15:0] CYCLES = `PDE_PROG_CYC
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic ce,
	input  wire logic start,
	output logic      done
);
	import pde_pkg::*;
	logic [15:0] cnt_q;
	// R23
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 16'h0000;
		end else if (ce) begin
			if (start)
				cnt_q <= CYCLES;
			else if (cnt_q != 16'h0000)
				cnt_q <= cnt_q - 16'h0001;
		end
	end
	assign done = ce && (cnt_q == 16'h0001);
endmodule
`default_nettype wire

// *** rtl/pde_host.sv ***
// cpu side: register port turned into core bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "pde_defines.svh"
module pde_host (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       ce,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            err,
	pde_if.host             bus
);
	import pde_pkg::*;
	// R17 R19 R20 are software duties; passed through as given; R18 reserved bits are cleared here
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bus.addr  <= 8'h00;
			bus.wdata <= 8'h00;
			bus.wr    <= 1'b0;
			bus.rd    <= 1'b0;
		end else if (ce) begin
			bus.addr  <= addr;
			// reserved control bits never leave this end set
			bus.wdata <= (addr == `PDE_CTL_ADDR)
				? (wdata & ~`PDE_RSVD_MASK) : wdata;      // R18
			bus.wr    <= wr;
			bus.rd    <= rd;
		end
	end
	assign rdata = bus.rdata;
	assign err   = bus.err;
endmodule
`default_nettype wire

// *** rtl/pde_dev.sv ***
// eeprom controller: bank, control register, array, row latches
`timescale 1ns/1ps
`default_nettype none
`include "pde_defines.svh"
module pde_dev #(
	parameter logic [15:0] PROG_CYCLES = `PDE_PROG_CYC
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic ce,
	pde_if.dev        bus,
	output logic      array_power_n
);
	import pde_pkg::*;
	// ***********************************************
	// storage
	// ***********************************************
	// no reset: contents outlive it, erased state is the start value
	pde_byte_t  mem_q [0:127] = '{default: `PDE_ERASED}; // R21
	pde_byte_t  latch_q [0:7];
	logic [7:0] loaded_q;
	logic [3:0] row_q;
	logic       row_valid_q;
	logic [7:0] bank_q;
	logic       ena_q, rowen_q, start_q, stby_q;
	pde_state_e state_q;
	logic       byte_mode_q;
	logic [6:0] baddr_q;
	pde_byte_t  bdata_q;
	logic       busy, done, win, page_ok, ctl_wr, ctl_rd, go;
	logic [6:0] ea;
	pde_byte_t  rdata_q;
	logic       err_q;

	function automatic logic page_sel(input logic [7:0] b);
		page_sel = (b == `PDE_BANK_P0) || (b == `PDE_BANK_P1);
	endfunction

	assign busy    = (state_q != PDE_IDLE);                    // R5
	assign win     = (bus.addr <= `PDE_WIN_TOP);               // R1
	assign page_ok = page_sel(bank_q) && !stby_q;              // R2 R22
	assign ea      = {bank_q[1], bus.addr[5:0]};               // R22
	assign ctl_wr  = bus.wr && (bus.addr == `PDE_CTL_ADDR);
	assign ctl_rd  = bus.rd && (bus.addr == `PDE_CTL_ADDR);
	assign array_power_n = stby_q;                             // R3
	// R15
	assign go = ctl_wr && !busy && bus.wdata[`PDE_BIT_START]
		&& ena_q && rowen_q;

	pde_prog_timer #(.CYCLES(PROG_CYCLES)) u_tmr (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ce      (ce),
		.start   (state_q == PDE_IDLE && (go || (bus.wr && win
			&& page_ok && ena_q && !rowen_q))),
		.done    (done)
	);

	// ***********************************************
	// bank select register
	// ***********************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			bank_q <= 8'h00;
		else if (ce && bus.wr && bus.addr == `PDE_BANK_ADDR)
			bank_q <= bus.wdata;
	end

	// ***********************************************
	// control register
	// ***********************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ena_q   <= 1'b0;
			rowen_q <= 1'b0;
			start_q <= 1'b0;
			stby_q  <= 1'b0;
		end else if (ce) begin
			if (done && state_q == PDE_PROG && !byte_mode_q) begin
				rowen_q <= 1'b0;                          // R14
				start_q <= 1'b0;                          // R14
			end else if (ctl_wr && !busy) begin               // R7
				ena_q   <= bus.wdata[`PDE_BIT_ENA];
				rowen_q <= bus.wdata[`PDE_BIT_ROWEN];
				stby_q  <= bus.wdata[`PDE_BIT_STBY];
				start_q <= go;                            // R15
			end
		end
	end

	// ***********************************************
	// programming sequencer
	// ***********************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q     <= PDE_IDLE;
			byte_mode_q <= 1'b0;
			baddr_q     <= 7'h00;
			bdata_q     <= 8'h00;
		end else if (ce) begin
			case (state_q)
			PDE_IDLE: begin
				if (go) begin                             // R13
					state_q     <= PDE_PROG;
					byte_mode_q <= 1'b0;
				end else if (bus.wr && win && page_ok && ena_q
					&& !rowen_q) begin               // R4 R9
					state_q     <= PDE_PROG;
					byte_mode_q <= 1'b1;
					baddr_q     <= ea;
					bdata_q     <= bus.wdata;
				end
			end
			PDE_PROG: begin
				if (done)                                 // R6 R23
					state_q <= PDE_DONE;
			end
			PDE_DONE: begin
				state_q <= PDE_IDLE;
			end
			default: state_q <= PDE_IDLE;
			endcase
		end
	end

	// ***********************************************
	// row latches
	// ***********************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			loaded_q    <= 8'h00;
			row_q       <= 4'h0;
			row_valid_q <= 1'b0;
		end else if (ce) begin
			if ((ctl_wr && !busy && bus.wdata[`PDE_BIT_ROWEN]
				&& !rowen_q) || !rowen_q) begin  // R11 R16
				loaded_q    <= 8'h00;
				row_valid_q <= 1'b0;
			end else if (!busy && !start_q && (bus.wr || bus.rd)
				&& win && page_ok) begin         // R12
				if (!row_valid_q || row_q == {ea[6], bus.addr[5:3]}) begin
					row_q       <= {ea[6], bus.addr[5:3]}; // R10
					row_valid_q <= 1'b1;
					if (bus.wr)
						loaded_q[bus.addr[2:0]] <= 1'b1;
				end
			end
		end
	end

	generate
		for (genvar i = 0; i < 8; i++) begin : g_lat
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst)
					latch_q[i] <= 8'h00;
				else if (ce) begin
					if (ctl_wr && !busy && bus.wdata[`PDE_BIT_ROWEN]
						&& !rowen_q)
						latch_q[i] <= 8'h00;          // R11
					else if (rowen_q && !busy && bus.wr && win && page_ok
						&& bus.addr[2:0] == 3'(i)
						&& (!row_valid_q
						|| row_q == {ea[6], bus.addr[5:3]}))
						latch_q[i] <= bus.wdata;
				end
			end
		end
	endgenerate

	// ***********************************************
	// array write port
	// ***********************************************
	always_ff @(posedge ref_clk) begin
		if (ce && done && state_q == PDE_PROG) begin
			if (byte_mode_q)
				mem_q[baddr_q] <= bdata_q;                // R9
			else
				for (int j = 0; j < 8; j++)
					if (loaded_q[j])                 // R13
						mem_q[{row_q, 3'(j)}] <= latch_q[j];
		end
	end

	// ***********************************************
	// read path, one cycle like ram
	// ***********************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
			err_q   <= 1'b0;
		end else if (ce) begin
			rdata_q <= 8'h00;
			err_q   <= 1'b0;
			if (ctl_rd) begin
				rdata_q <= {6'h00, busy, 1'b0};           // R5 R7
			end else if (bus.rd && win) begin
				if (busy || !page_ok || rowen_q)          // R2 R6
					err_q <= 1'b1;
				else
					rdata_q <= mem_q[ea];             // R8
			end else if (bus.wr && win) begin
				err_q <= busy || !page_ok || (rowen_q && row_valid_q
					&& row_q != {ea[6], bus.addr[5:3]}); // R6 R12
			end
		end
	end
	assign bus.rdata = rdata_q;
	assign bus.err   = err_q;
endmodule
`default_nettype wire

// *** sim/pde_monitor.sv ***
// bus assertions between host and device ends
`timescale 1ns/1ps
`default_nettype none
module pde_monitor (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       err
);
	// ****
	// bus checks
	// ****
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire win_rd = rd && addr <= 8'h3f;
	wire ctl_rd = rd && addr == 8'hdf;
	sequence prog_s;
		wr && addr == 8'hcb && wdata == 8'h01 ##1
		wr && addr == 8'hdf && wdata == 8'h01 ##1 wr && addr == 8'h05;
	endsequence
	rdata_idle_a: assert property (
		!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
	err_cause_a: assert property (
		err |-> $past(wr || rd)) else $error("error without access");
	ctl_read_a: assert property (
		$past(ctl_rd) |-> rdata[7:2] == 6'h00 && !rdata[0] && !err)
		else $error("control read shows more than busy");
	no_page_a: assert property (
		wr && addr == 8'hcb && wdata == 8'h00 ##1 win_rd |=> err)
		else $error("access with no page not refused");
	standby_a: assert property (
		wr && addr == 8'hdf && wdata[6] ##1 win_rd |=> err)
		else $error("access in standby not refused");
	row_read_a: assert property (
		wr && addr == 8'hdf && wdata == 8'h05 ##1 win_rd |=> err)
		else $error("read in row mode not refused");
	busy_set_a: assert property (
		prog_s ##1 ctl_rd |=> rdata[1]) else $error("busy not set");
	busy_abort_a: assert property (
		prog_s ##1 win_rd |=> err) else $error("access while busy taken");
	rsvd_zero_a: assert property (
		wr && addr == 8'hdf |-> wdata[5:4] == 2'b00)
		else $error("reserved control bits driven");
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// testbench joining host and device ends over the core bus
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       ref_clk = 1'b0;
	logic       nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       err;
	logic       pwr_n;
	logic [7:0] row_exp [8] = '{8'h11, 8'hff, 8'h22, 8'h33,
		8'hff, 8'hff, 8'hff, 8'hff};
	int         fails = 0;
	int         checked = 0;
	int         cycles = 0;
	pde_if bus_if ();
	pde_host i_pde_host (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.err(err), .bus(bus_if));
	// short programming time keeps the run brief
	pde_dev #(.PROG_CYCLES(16'h0008)) i_pde_dev (.ref_clk(ref_clk),
		.nrst(nrst), .ce(1'b1), .bus(bus_if), .array_power_n(pwr_n));
	pde_monitor i_pde_monitor (.ref_clk(ref_clk), .nrst(nrst),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
		.rd(bus_if.rd), .rdata(bus_if.rdata), .err(bus_if.err));
	// ****
	// tasks
	// ****
	always #4 ref_clk = ~ref_clk;
	task end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			end_sim();
		end
	end
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask
	// strobe stays up so writes run back to back
	task put(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
	endtask
	task get(input logic [7:0] a, output logic [7:0] v, output logic e);
		@(posedge ref_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(posedge ref_clk);
		#1;
		v = rdata;
		e = err;
	endtask
	task chk(input logic [7:0] a, input logic [7:0] exp, input logic ee);
		logic [7:0] v;
		logic       e;
		get(a, v, e);
		cmp_bit(e, ee);
		if (!ee)
			cmp(v, exp);
	endtask
	task wait_idle;
		logic [7:0] v;
		logic       e;
		int         n;
		n = 0;
		do begin
			get(8'hdf, v, e);
			n++;
		end while (v[1] !== 1'b0 && n < 20);
		cmp_bit(v[1], 1'b0);
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		chk(8'hdf, 8'h00, 1'b0);
		chk(8'h05, 8'h00, 1'b1);
		put(8'hcb, 8'h01);
		chk(8'h00, 8'hff, 1'b0);
		chk(8'h3f, 8'hff, 1'b0);
		put(8'h05, 8'haa);
		chk(8'h05, 8'hff, 1'b0);
		$display("test reset done");
		put(8'hcb, 8'h01);
		put(8'hdf, 8'h01);
		put(8'h05, 8'haa);
		chk(8'hdf, 8'h02, 1'b0);
		put(8'hdf, 8'h40);
		wait_idle();
		chk(8'h05, 8'haa, 1'b0);
		put(8'hcb, 8'h01);
		put(8'hdf, 8'h01);
		put(8'h06, 8'h55);
		chk(8'h06, 8'h00, 1'b1);
		wait_idle();
		chk(8'h06, 8'h55, 1'b0);
		chk(8'h05, 8'haa, 1'b0);
		put(8'hcb, 8'h02);
		chk(8'h05, 8'hff, 1'b0);
		$display("test byte done");
		put(8'hcb, 8'h01);
		put(8'hdf, 8'h05);
		chk(8'h18, 8'h00, 1'b1);
		put(8'h18, 8'h11);
		put(8'h1a, 8'h22);
		put(8'h1b, 8'h33);
		put(8'hdf, 8'h0d);
		wait_idle();
		for (int i = 0; i < 8; i++)
			chk(8'h18 + 8'(i), row_exp[i], 1'b0);
		put(8'hdf, 8'h09);
		chk(8'hdf, 8'h00, 1'b0);
		put(8'hdf, 8'h05);
		put(8'h28, 8'h77);
		put(8'hdf, 8'h01);
		put(8'hdf, 8'h09);
		chk(8'hdf, 8'h00, 1'b0);
		chk(8'h28, 8'hff, 1'b0);
		$display("test row done");
		put(8'hdf, 8'h30);
		put(8'hdf, 8'h40);
		chk(8'h05, 8'h00, 1'b1);
		cmp_bit(pwr_n, 1'b1);
		put(8'hdf, 8'h00);
		chk(8'h05, 8'haa, 1'b0);
		cmp_bit(pwr_n, 1'b0);
		put(8'hcb, 8'h00);
		chk(8'h05, 8'h00, 1'b1);
		$display("test standby done");
		end_sim();
	end
endmodule
`default_nettype wire
